// ===== dacu_map.svh
`ifndef DACU_MAP_SVH
`define DACU_MAP_SVH

// ---------------------------------------------------------------
// Register offsets.
// ---------------------------------------------------------------
`define DACU_OFF_PAGE_SELECT      4'h1
`define DACU_OFF_STATUS           4'h3
`define DACU_OFF_CODE_LOW         4'h6
`define DACU_OFF_CODE_HIGH_CH     4'h7
`define DACU_OFF_IO_MODE          4'hB
`define DACU_OFF_RANGE_CFG        4'hE
`define DACU_OFF_WIDE_HIGH_UPD    4'hF
`define DACU_PAGE_EXPANDED        2'h2

// ---------------------------------------------------------------
// Field positions.
// ---------------------------------------------------------------
`define DACU_BIT_BUSY             4
`define DACU_BIT_WIDE_RES         6
`define DACU_BIT_SIM_UPDATE       5
`define DACU_BIT_PER_CH_RANGE     7
`define DACU_BIT_POLARITY         3
`define DACU_LSB_LOAD_CH          6
`define DACU_LSB_RANGE_CH         4

// ---------------------------------------------------------------
// Reset values and timing.
// ---------------------------------------------------------------
`define DACU_RST_IO_MODE          8'h1B
`define DACU_RST_PAGE             2'h0
`define DACU_BUSY_TIME_NS         4000
`define DACU_CLK_PERIOD_NS        20
`define DACU_BUSY_CYCLES          ((`DACU_BUSY_TIME_NS + `DACU_CLK_PERIOD_NS - 1) / `DACU_CLK_PERIOD_NS)

`endif

// ===== dacu_pkg.sv
package dacu_pkg;

   // Host register access for one clock cycle.
   typedef struct packed {
      logic [3:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } dacu_bus_req_t;

   // Range setting of one output channel.
   typedef struct packed {
      logic       polarity;
      logic [1:0] gain;
   } dacu_range_t;

endpackage : dacu_pkg

// ===== dacu_busy_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "dacu_map.svh"

module dacu_busy_timer #(
   parameter int CYCLES = `DACU_BUSY_CYCLES
) (
   // Clock and reset.
   input  wire logic i_clk_sys,
   input  wire logic i_rst_n,
   // Control.
   input  wire logic i_start,
   output logic      o_busy
);

   // ---------------------------------------------------------------
   // Elaboration check.
   // ---------------------------------------------------------------
   if (CYCLES < 1) begin : g_chk
      $error("dacu_busy_timer: CYCLES must be at least one");
   end

   localparam int CW = $clog2(CYCLES + 1);

   logic [CW-1:0] cnt_ff;
   logic [CW-1:0] nxt_cnt;
   logic          busy_ff;
   logic          nxt_busy;

   // The interval is counted on the system clock so it never falls short.
   always_comb begin
      nxt_cnt  = cnt_ff;
      nxt_busy = busy_ff;
      if (i_start && !busy_ff) begin
         nxt_cnt  = CW'(CYCLES - 1);
         nxt_busy = 1'b1;
      end else if (busy_ff) begin
         if (cnt_ff == '0) begin
            nxt_busy = 1'b0;
         end else begin
            nxt_cnt = cnt_ff - CW'(1);
         end
      end
   end

   // Registers; reset leaves the converter idle.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         cnt_ff  <= '0;
         busy_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         busy_ff <= nxt_busy;
      end
   end

   assign o_busy = busy_ff;

endmodule : dacu_busy_timer
`default_nettype wire

// ===== dacu_range_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "dacu_map.svh"

module dacu_range_bank #(
   parameter int NUM_CH = 4
) (
   // Clock and reset.
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_rst_n,
   // Range write.
   input  wire logic                  i_wr,
   input  wire logic [7:0]            i_wdata,
   // Ranges per channel.
   output dacu_pkg::dacu_range_t      o_range [NUM_CH]
);

   // ---------------------------------------------------------------
   // Elaboration check.
   // ---------------------------------------------------------------
   if (NUM_CH != 4) begin : g_chk
      $error("dacu_range_bank: the channel field selects exactly four channels");
   end

   logic       per_ch;
   logic [1:0] sel_ch;
   logic       legal;
   dacu_pkg::dacu_range_t wr_range;

   // Decode the written byte once for all channels.
   always_comb begin
      per_ch            = i_wdata[`DACU_BIT_PER_CH_RANGE];
      sel_ch            = i_wdata[`DACU_LSB_RANGE_CH +: 2];
      wr_range.polarity = i_wdata[`DACU_BIT_POLARITY];
      wr_range.gain     = i_wdata[1:0];
      // Unipolar with gain code 2 is not a range; the write is dropped.
      legal = !(!wr_range.polarity && wr_range.gain == 2'h2);
   end

   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      dacu_pkg::dacu_range_t range_ff;
      dacu_pkg::dacu_range_t nxt_range;

      // A broadcast write hits every channel, a selective one only its own.
      always_comb begin
         nxt_range = range_ff;
         if (i_wr && legal && (!per_ch || sel_ch == 2'(ch))) begin
            nxt_range = wr_range;
         end
      end

      // Registers; reset gives the unipolar 5 V range.
      always_ff @(posedge i_clk_sys) begin
         if (!i_rst_n) begin
            range_ff <= '0;
         end else begin
            range_ff <= nxt_range;
         end
      end

      assign o_range[ch] = range_ff;
   end

endmodule : dacu_range_bank
`default_nettype wire

// ===== dacu_top.sv
// Function
// - Low code byte from offset six.
// - Narrow mode: high nibble from offset seven.
// - Wide mode: high byte from page-two fifteen.
// - Offset seven bits 7-6 pick load channel.
// - Offset eleven bit 6 selects wide resolution.
// - Offset eleven bit 5 selects simultaneous update.
// - Immediate mode: channel write starts update.
// - Busy flag, offset three bit 4, during update.
// - Busy blocks data, channel, wide-byte writes.
// - Simultaneous mode: page-two fifteen read updates.
// - Simultaneous update refreshes all four channels.
// - Update mode held until changed or reset.
// - Range bit 7 selects one or all channels.
// - Range bits 5-4 pick the channel.
// - Range bit 3 polarity, bits 1-0 gain.
// - Decode range; unipolar gain 2 ignored.
// - Offset one page select gates page two.
`timescale 1ns/1ps
`default_nettype none
`include "dacu_map.svh"

module dacu_top #(
   parameter int NUM_CH      = 4,
   parameter int CODE_W      = 16,
   parameter int BUSY_CYCLES = `DACU_BUSY_CYCLES
) (
   // Clock and reset.
   input  wire logic                   i_clk_sys,
   input  wire logic                   i_rst_n,
   // Host register port.
   input  wire dacu_pkg::dacu_bus_req_t i_bus,
   output logic [7:0]                  o_rdata,
   output logic                        o_rvalid,
   // Converter side.
   output logic [CODE_W-1:0]           o_ch_code [NUM_CH],
   output dacu_pkg::dacu_range_t       o_ch_range [NUM_CH],
   output logic [NUM_CH-1:0]           o_ch_shutdown,
   output logic                        o_update,
   output logic                        o_busy
);

   // ---------------------------------------------------------------
   // Elaboration checks.
   // ---------------------------------------------------------------
   if (NUM_CH != 4) begin : g_chk_ch
      $error("dacu_top: the channel field selects exactly four channels");
   end
   if (CODE_W != 16) begin : g_chk_w
      $error("dacu_top: the code is built from two bytes, CODE_W must be 16");
   end

   // ---------------------------------------------------------------
   // Access decode.
   // ---------------------------------------------------------------
   logic [1:0]  page_ff;
   logic        busy;
   logic        on_page2;
   logic        wr_page;
   logic        wr_low;
   logic        wr_high_ch;
   logic        wr_mode;
   logic        wr_range;
   logic        wr_wide;
   logic        rd_wide;

   // Page-two registers are invisible on any other page.
   always_comb begin
      on_page2   = (page_ff == `DACU_PAGE_EXPANDED);
      wr_page    = i_bus.wr && i_bus.addr == `DACU_OFF_PAGE_SELECT;
      wr_mode    = i_bus.wr && i_bus.addr == `DACU_OFF_IO_MODE;
      // Converter data writes are dropped while an update runs.
      wr_low     = i_bus.wr && !busy && i_bus.addr == `DACU_OFF_CODE_LOW;
      wr_high_ch = i_bus.wr && !busy && i_bus.addr == `DACU_OFF_CODE_HIGH_CH;
      wr_wide    = i_bus.wr && !busy && on_page2
                   && i_bus.addr == `DACU_OFF_WIDE_HIGH_UPD;
      wr_range   = i_bus.wr && on_page2 && i_bus.addr == `DACU_OFF_RANGE_CFG;
      rd_wide    = i_bus.rd && on_page2 && i_bus.addr == `DACU_OFF_WIDE_HIGH_UPD;
   end

   // ---------------------------------------------------------------
   // Page and mode registers.
   // ---------------------------------------------------------------
   logic [1:0]  nxt_page;
   logic [7:0]  io_mode_ff;
   logic [7:0]  nxt_io_mode;
   logic        wide_res;
   logic        sim_mode;

   // The mode byte also carries the digital port bits; all are kept as written.
   always_comb begin
      nxt_page    = page_ff;
      nxt_io_mode = io_mode_ff;
      if (wr_page) begin
         nxt_page = i_bus.wdata[1:0];
      end
      if (wr_mode) begin
         nxt_io_mode = i_bus.wdata;
      end
   end

   // Registers; reset drops both converter modes and sets ports to input.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         page_ff    <= `DACU_RST_PAGE;
         io_mode_ff <= `DACU_RST_IO_MODE;
      end else begin
         page_ff    <= nxt_page;
         io_mode_ff <= nxt_io_mode;
      end
   end

   assign wide_res = io_mode_ff[`DACU_BIT_WIDE_RES];
   assign sim_mode = io_mode_ff[`DACU_BIT_SIM_UPDATE];

   // ---------------------------------------------------------------
   // Code assembly.
   // ---------------------------------------------------------------
   logic [7:0]        code_low_ff;
   logic [7:0]        nxt_code_low;
   logic [7:0]        wide_high_ff;
   logic [7:0]        nxt_wide_high;
   logic [CODE_W-1:0] load_code;
   logic [1:0]        load_ch;

   // The low byte serves both widths; the high part depends on resolution.
   always_comb begin
      nxt_code_low  = code_low_ff;
      nxt_wide_high = wide_high_ff;
      if (wr_low) begin
         nxt_code_low = i_bus.wdata;
      end
      if (wr_wide) begin
         nxt_wide_high = i_bus.wdata;
      end
      load_ch = i_bus.wdata[`DACU_LSB_LOAD_CH +: 2];
      if (wide_res) begin
         // The channel write carries no data bits in wide mode.
         load_code = {wide_high_ff, code_low_ff};
      end else begin
         load_code = {4'h0, i_bus.wdata[3:0], code_low_ff};
      end
   end

   // Registers for the partial code bytes.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         code_low_ff  <= 8'h00;
         wide_high_ff <= 8'h00;
      end else begin
         code_low_ff  <= nxt_code_low;
         wide_high_ff <= nxt_wide_high;
      end
   end

   // ---------------------------------------------------------------
   // Channel data and update control.
   // ---------------------------------------------------------------
   logic [CODE_W-1:0] pend_ff   [NUM_CH];
   logic [CODE_W-1:0] active_ff [NUM_CH];
   logic              start_upd;
   logic              update_ff;
   logic              nxt_update;

   // Immediate mode updates on the channel write, simultaneous on the read.
   always_comb begin
      start_upd  = (wr_high_ch && !sim_mode)
                   || (rd_wide && sim_mode && !busy);
      nxt_update = start_upd;
   end

   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic [CODE_W-1:0] nxt_pend;
      logic [CODE_W-1:0] nxt_active;
      logic              hit;
      logic              shut_ff;
      logic              nxt_shut;
      logic              rng_hit;

      // Unchanged channels reload their old code, so they hold steady.
      always_comb begin
         hit        = wr_high_ch && load_ch == 2'(ch);
         nxt_pend   = pend_ff[ch];
         nxt_active = active_ff[ch];
         if (hit) begin
            nxt_pend = load_code;
         end
         if (hit && !sim_mode) begin
            nxt_active = load_code;
         end else if (rd_wide && sim_mode && !busy) begin
            nxt_active = pend_ff[ch];
         end
         // The shutdown flag is decoded from the range write itself, so it
         // lands on the same edge as the range and still leaves a flop.
         rng_hit  = wr_range
                    && !(!i_bus.wdata[`DACU_BIT_POLARITY] && i_bus.wdata[1:0] == 2'h2)
                    && (!i_bus.wdata[`DACU_BIT_PER_CH_RANGE]
                        || i_bus.wdata[`DACU_LSB_RANGE_CH +: 2] == 2'(ch));
         nxt_shut = shut_ff;
         if (rng_hit) begin
            nxt_shut = (i_bus.wdata[1:0] == 2'h3);
         end
      end

      // Codes start at zero; shutdown flags start clear, matching the reset range.
      always_ff @(posedge i_clk_sys) begin
         if (!i_rst_n) begin
            pend_ff[ch]   <= '0;
            active_ff[ch] <= '0;
            shut_ff       <= 1'b0;
         end else begin
            pend_ff[ch]   <= nxt_pend;
            active_ff[ch] <= nxt_active;
            shut_ff       <= nxt_shut;
         end
      end

      assign o_ch_code[ch]     = active_ff[ch];
      assign o_ch_shutdown[ch] = shut_ff;
   end

   // Update strobe toward the converter.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         update_ff <= 1'b0;
      end else begin
         update_ff <= nxt_update;
      end
   end

   assign o_update = update_ff;

   // ---------------------------------------------------------------
   // Busy interval and ranges.
   // ---------------------------------------------------------------
   dacu_busy_timer #(
      .CYCLES    (BUSY_CYCLES)
   ) u_busy (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_start   (start_upd),
      .o_busy    (busy)
   );

   dacu_range_bank #(
      .NUM_CH    (NUM_CH)
   ) u_range (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_wr      (wr_range),
      .i_wdata   (i_bus.wdata),
      .o_range   (o_ch_range)
   );

   // The busy flag comes straight from the timer's own flop.
   assign o_busy = busy;

   // ---------------------------------------------------------------
   // Read path.
   // ---------------------------------------------------------------
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic       rvalid_ff;

   // Write-only offsets read as zero; the update read returns zero as well.
   always_comb begin
      nxt_rdata = 8'h00;
      if (i_bus.rd) begin
         unique case (i_bus.addr)
            `DACU_OFF_STATUS: begin
               nxt_rdata[`DACU_BIT_BUSY] = busy;
            end
            `DACU_OFF_IO_MODE: begin
               nxt_rdata = io_mode_ff;
            end
            default: begin
               nxt_rdata = 8'h00;
            end
         endcase
      end
   end

   // The answer follows the read strobe by one clock.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         rdata_ff  <= 8'h00;
         rvalid_ff <= 1'b0;
      end else begin
         rdata_ff  <= nxt_rdata;
         rvalid_ff <= i_bus.rd;
      end
   end

   assign o_rdata  = rdata_ff;
   assign o_rvalid = rvalid_ff;

endmodule : dacu_top
`default_nettype wire

// ===== dacu_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// Port checker for the converter control.
// ------------------------------------------
module dacu_chk #(
   parameter int NUM_CH      = 4,
   parameter int CODE_W      = 16,
   parameter int BUSY_CYCLES = 200
) (
   // Clock and reset.
   input wire logic                    i_clk_sys,
   input wire logic                    i_rst_n,
   // Host port.
   input wire dacu_pkg::dacu_bus_req_t i_bus,
   input wire logic [7:0]              o_rdata,
   input wire logic                    o_rvalid,
   // Converter side.
   input wire logic [CODE_W-1:0]       o_ch_code [NUM_CH],
   input wire dacu_pkg::dacu_range_t   o_ch_range [NUM_CH],
   input wire logic [NUM_CH-1:0]       o_ch_shutdown,
   input wire logic                    o_update,
   input wire logic                    o_busy
);
   logic        sim_ff;
   logic        wide_ff;
   logic [1:0]  page_ff;
   logic [7:0]  low_ff;
   logic [7:0]  hi_ff;
   logic [15:0] cnt_ff;
   logic        w7;
   logic        wre;
   logic [2:0]  rng;
   logic [15:0] exp_code;
   // Decoded accesses and the code a channel write should produce.
   assign w7       = i_bus.wr && !o_busy && i_bus.addr == 4'h7;
   assign wre      = i_bus.wr && i_bus.addr == 4'hE && page_ff == 2'h2;
   assign rng      = {i_bus.wdata[3], i_bus.wdata[1:0]};
   assign exp_code = wide_ff ? {hi_ff, low_ff} : {4'h0, i_bus.wdata[3:0], low_ff};
   // Shadow state; data bytes follow only writes taken while idle.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         sim_ff  <= 1'b0;
         wide_ff <= 1'b0;
         page_ff <= 2'h0;
         low_ff  <= 8'h00;
         hi_ff   <= 8'h00;
         cnt_ff  <= 16'h0000;
      end else begin
         cnt_ff <= o_busy ? cnt_ff + 16'h0001 : 16'h0000;
         if (i_bus.wr && i_bus.addr == 4'hB) begin
            sim_ff  <= i_bus.wdata[5];
            wide_ff <= i_bus.wdata[6];
         end
         if (i_bus.wr && i_bus.addr == 4'h1) page_ff <= i_bus.wdata[1:0];
         if (i_bus.wr && !o_busy && i_bus.addr == 4'h6) low_ff <= i_bus.wdata;
         if (i_bus.wr && !o_busy && i_bus.addr == 4'hF && page_ff == 2'h2) hi_ff <= i_bus.wdata;
      end
   end
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);
   property p_status;
      i_bus.rd && i_bus.addr == 4'h3 |=> o_rvalid && o_rdata[4] == $past(o_busy);
   endproperty
   a_status: assert property (p_status) else $error("status flag wrong");
   property p_busy_len;
      $fell(o_busy) |-> cnt_ff == BUSY_CYCLES;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
   property p_start;
      $rose(o_busy) |-> o_update;
   endproperty
   a_start: assert property (p_start) else $error("busy without update");
   property p_load;
      w7 && !sim_ff |=> o_update && o_ch_code[$past(i_bus.wdata[7:6])] == $past(exp_code);
   endproperty
   a_load: assert property (p_load) else $error("channel load wrong");
   property p_block;
      i_bus.wr && o_busy && i_bus.addr == 4'h7 |=>
         o_ch_code[$past(i_bus.wdata[7:6])] == $past(o_ch_code[i_bus.wdata[7:6]]);
   endproperty
   a_block: assert property (p_block) else $error("busy write taken");
   property p_hold;
      w7 && sim_ff |=> !o_update;
   endproperty
   a_hold: assert property (p_hold) else $error("held mode updated");
   property p_sim;
      i_bus.rd && i_bus.addr == 4'hF && page_ff == 2'h2 && sim_ff && !o_busy |=> o_update;
   endproperty
   a_sim: assert property (p_sim) else $error("update command lost");
   property p_page;
      i_bus.rd && i_bus.addr == 4'hF && page_ff != 2'h2 |=> !o_update;
   endproperty
   a_page: assert property (p_page) else $error("page gate open");
   property p_all;
      wre && !i_bus.wdata[7] && rng != 3'h2 |=> o_ch_range[0] == $past(rng) && o_ch_range[3] == $past(rng);
   endproperty
   a_all: assert property (p_all) else $error("global range wrong");
   property p_one;
      wre && i_bus.wdata[7] && rng != 3'h2 |=> o_ch_range[$past(i_bus.wdata[5:4])] == $past(rng);
   endproperty
   a_one: assert property (p_one) else $error("channel range wrong");
   property p_shut;
      o_ch_shutdown[0] == (o_ch_range[0].gain == 2'h3) && o_ch_shutdown[2] == (o_ch_range[2].gain == 2'h3);
   endproperty
   a_shut: assert property (p_shut) else $error("shutdown decode wrong");
endmodule : dacu_chk
bind dacu_top dacu_chk #(
   .NUM_CH      (NUM_CH),
   .CODE_W      (CODE_W),
   .BUSY_CYCLES (BUSY_CYCLES)
) u_chk (
   .i_clk_sys     (i_clk_sys),
   .i_rst_n       (i_rst_n),
   .i_bus         (i_bus),
   .o_rdata       (o_rdata),
   .o_rvalid      (o_rvalid),
   .o_ch_code     (o_ch_code),
   .o_ch_range    (o_ch_range),
   .o_ch_shutdown (o_ch_shutdown),
   .o_update      (o_update),
   .o_busy        (o_busy)
);
`default_nettype wire

// ===== dacu_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// Behavioural four-channel converter chip.
// ------------------------------------------
module dacu_conv_model (
   // Clock and load strobe.
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_update,
   // Codes and ranges from the control block.
   input  wire logic [15:0]           i_code [4],
   input  wire dacu_pkg::dacu_range_t i_range [4],
   // Held output state and load marker.
   output logic [75:0]                o_held,
   output logic                       o_loaded
);
   // Every strobe reloads all four channels, so untouched ones stay steady.
   always_ff @(posedge i_clk_sys) begin
      o_loaded <= i_update;
      if (i_update) begin
         for (int i = 0; i < 4; i++) begin
            o_held[16*i +: 16]  <= i_code[i];
            o_held[64+3*i +: 3] <= i_range[i];
         end
      end
   end
endmodule : dacu_conv_model
`default_nettype wire

// ===== dacu_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dacu_top_tb;
   logic                    i_clk_sys;
   logic                    i_rst_n;
   dacu_pkg::dacu_bus_req_t i_bus;
   logic [7:0]              o_rdata;
   logic                    o_rvalid;
   logic [15:0]             o_ch_code [4];
   dacu_pkg::dacu_range_t   o_ch_range [4];
   logic [3:0]              o_ch_shutdown;
   logic                    o_update;
   logic                    o_busy;
   logic [75:0]             held;
   logic                    loaded;
   logic [15:0]             rd_q [$];
   logic [79:0]             upd_q [$];
   logic [15:0]             cur [4];
   logic [15:0]             pend [4];
   logic [2:0]              rng [4];
   logic [15:0]             c;
   logic [7:0]              r;
   logic [7:0]              d;
   logic [15:0]             note;
   int                      seed = 32'h35035306;
   int                      miscompares = 0;
   int                      samples_checked = 0;
   // ------------------------------------------
   // Design, far-side model and clock.
   // ------------------------------------------
   dacu_top #(.BUSY_CYCLES(10)) dut (
      .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_bus(i_bus), .o_rdata(o_rdata),
      .o_rvalid(o_rvalid), .o_ch_code(o_ch_code), .o_ch_range(o_ch_range),
      .o_ch_shutdown(o_ch_shutdown), .o_update(o_update), .o_busy(o_busy));
   dacu_conv_model u_conv (
      .i_clk_sys(i_clk_sys), .i_update(o_update), .i_code(o_ch_code),
      .i_range(o_ch_range), .o_held(held), .o_loaded(loaded));
   initial begin
      i_clk_sys = 1'b0;
      forever #10 i_clk_sys = ~i_clk_sys;
   end
   // ------------------------------------------
   // Tasks.
   // ------------------------------------------
   task automatic finish_test();
      if (miscompares == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input logic [79:0] got, input logic [79:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus_op(input logic [3:0] a, input logic w, input logic [7:0] v);
      @(posedge i_clk_sys);
      i_bus <= '{addr: a, wr: w, rd: !w, wdata: v};
      @(posedge i_clk_sys);
      i_bus <= '0;
   endtask : bus_op
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      bus_op(a, 1'b1, v);
   endtask : wr
   // A read leaves its expected value and mask for the watcher.
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
      rd_q.push_back({e, m});
      bus_op(a, 1'b0, 8'h00);
   endtask : rd
   function automatic logic [79:0] pack();
      logic [79:0] v;
      for (int i = 0; i < 4; i++) begin
         v[16*i +: 16]  = cur[i];
         v[64+3*i +: 3] = rng[i];
         v[76+i]        = (rng[i][1:0] == 2'h3);
      end
      return v;
   endfunction : pack
   // Loads one channel; only immediate mode expects an update at once.
   task automatic load(input logic [1:0] ch, input logic [15:0] v, input logic wide, input logic sim);
      pend[ch] = v;
      if (!sim) begin
         cur[ch] = v;
         upd_q.push_back(pack());
      end
      wr(4'h6, v[7:0]);
      if (wide) wr(4'hF, v[15:8]);
      wr(4'h7, {ch, 2'h0, wide ? 4'h0 : v[11:8]});
   endtask : load
   // Polls the o_busy port at each falling edge, bounded at 1000 cycles against a hang.
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         @(negedge i_clk_sys);
         n++;
      end while (o_busy !== 1'b0 && n < 1000);
      if (n >= 1000) begin
         miscompares++;
         finish_test();
      end
   endtask : wait_idle
   task automatic rst(input int n);
      @(posedge i_clk_sys);
      i_rst_n <= 1'b0;
      repeat (n) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         cur[k]  = 16'h0000;
         pend[k] = 16'h0000;
         rng[k]  = 3'h0;
      end
   endtask : rst
   // ------------------------------------------
   // Watcher: each result takes the oldest note.
   // ------------------------------------------
   always @(negedge i_clk_sys) begin
      if (o_rvalid === 1'b1 && rd_q.size() > 0) begin
         note = rd_q.pop_front();
         chk(80'(o_rdata & note[7:0]), 80'(note[15:8] & note[7:0]));
      end else if (o_rvalid === 1'b1) chk(80'h1, 80'h0);
      if (loaded === 1'b1 && upd_q.size() > 0)
         chk({o_ch_shutdown, held}, upd_q.pop_front());
      else if (loaded === 1'b1) chk(80'h1, 80'h0);
   end
   initial begin
      repeat (50000) @(posedge i_clk_sys);
      miscompares++;
      finish_test();
   end
   // ------------------------------------------
   // Main sequence.
   // ------------------------------------------
   initial begin
      i_rst_n = 1'b0;
      i_bus   = '0;
      rst(4);
      rd(4'hB, 8'h1B, 8'hFF);
      rd(4'h3, 8'h00, 8'h10);
      rd(4'h6, 8'h00, 8'hFF);
      for (int i = 0; i < 4; i++) begin
         c = 16'($random(seed)) & 16'h0FFF;
         load(i[1:0], c, 1'b0, 1'b0);
         rd(4'h3, 8'h10, 8'h10);
         wr(4'h6, ~c[7:0]);
         wr(4'h7, {i[1:0], 6'h0F});
         wait_idle();
         rd(4'h3, 8'h00, 8'h10);
      end
      cur[1] = {4'h0, 4'hA, c[7:0]};
      pend[1] = cur[1];
      upd_q.push_back(pack());
      wr(4'h7, 8'h4A);
      wait_idle();
      wr(4'hB, 8'h3B);
      wr(4'h1, 8'h02);
      for (int i = 0; i < 16; i++) begin
         r = 8'($random(seed));
         d = {i[3], 1'b0, r[1:0], i[2], 1'b0, i[1:0]};
         wr(4'hE, d);
         for (int k = 0; k < 4; k++) begin
            if ({d[3], d[1:0]} != 3'h2 && (!d[7] || k == d[5:4])) rng[k] = {d[3], d[1:0]};
         end
         c = 16'($random(seed)) & 16'h0FFF;
         load(r[3:2], c, 1'b0, 1'b1);
         for (int k = 0; k < 4; k++) cur[k] = pend[k];
         upd_q.push_back(pack());
         rd(4'hF, 8'h00, 8'hFF);
         wait_idle();
      end
      wr(4'h1, 8'h00);
      wr(4'hE, 8'h03);
      rd(4'hF, 8'h00, 8'hFF);
      wr(4'h1, 8'h02);
      upd_q.push_back(pack());
      rd(4'hF, 8'h00, 8'hFF);
      rd(4'hF, 8'h00, 8'hFF);
      wait_idle();
      wr(4'hB, 8'h5B);
      for (int i = 0; i < 2; i++) begin
         c = 16'($random(seed));
         load(2'(i + 2), c, 1'b1, 1'b0);
         wr(4'hF, ~c[15:8]);
         wait_idle();
      end
      cur[3] = {c[15:8], 8'h77};
      pend[3] = cur[3];
      upd_q.push_back(pack());
      wr(4'h6, 8'h77);
      wr(4'h7, 8'hC0);
      wait_idle();
      rst(2);
      rd(4'hB, 8'h1B, 8'hFF);
      load(2'h0, 16'h0123, 1'b0, 1'b0);
      wait_idle();
      repeat (4) @(posedge i_clk_sys);
      miscompares += rd_q.size() + upd_q.size();
      finish_test();
   end
endmodule : dacu_top_tb
`default_nettype wire
